// *** sbs_pkg.sv ***
package sbs_pkg;

    // register offsets on the configuration port
    localparam logic [7:0]  SBS_OFS_CTRL     = 8'h10;
    localparam logic [7:0]  SBS_OFS_GEOM     = 8'h14;
    localparam logic [7:0]  SBS_OFS_ENDS     = 8'h18;
    localparam logic [7:0]  SBS_OFS_PAGES    = 8'h1C;

    // values after reset
    localparam logic [2:0]  SBS_MODE_RST     = 3'h0;
    localparam logic [15:0] SBS_GEOM_RST     = 16'h0000;
    localparam logic [31:0] SBS_ENDS_RST     = 32'h00000000;

    // command override field encodings
    localparam logic [2:0]  SBS_MODE_NORMAL  = 3'h0;
    localparam logic [2:0]  SBS_MODE_NOP     = 3'h1;
    localparam logic [2:0]  SBS_MODE_PRE_ALL = 3'h2;
    localparam logic [2:0]  SBS_MODE_LOAD    = 3'h3;
    localparam logic [2:0]  SBS_MODE_REFRESH = 3'h4;

    // field positions and widths
    localparam int          SBS_MODE_POS     = 0;
    localparam int          SBS_COL_POS      = 0;
    localparam int          SBS_IB4_POS      = 3;
    localparam int          SBS_NIB_W        = 4;
    localparam int          SBS_END_W        = 8;
    localparam int          SBS_END_EN_POS   = 7;
    localparam int          SBS_UNIT_LSB     = 22;
    localparam int          SBS_UNIT_W       = 7;
    localparam int          SBS_MA_PRE_POS   = 10;
    localparam int          SBS_ROW_LOW_W    = 11;

    localparam int          SBS_EXT_BANKS    = 4;
    localparam int          SBS_INT_BANKS    = 4;
    localparam int          SBS_PAGES        = SBS_EXT_BANKS * SBS_INT_BANKS;
    localparam int          SBS_ROW_W        = 13;
    localparam int          SBS_COL_W        = 11;
    localparam int          SBS_MA_W         = 13;

    typedef enum logic [2:0] {
        SBS_CMD_NOP      = 3'h0,
        SBS_CMD_PRE_ALL  = 3'h1,
        SBS_CMD_LOAD     = 3'h3,
        SBS_CMD_REFRESH  = 3'h2,
        SBS_CMD_ACC_OPEN = 3'h6,
        SBS_CMD_ACC_HIT  = 3'h7,
        SBS_CMD_ACC_SWAP = 3'h5
    } sbs_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } sbs_req_t;

    typedef struct packed {
        logic                 valid;
        sbs_cmd_t             cmd;
        logic                 write;
        logic [3:0]           cs;
        logic [1:0]           ib;
        logic [SBS_ROW_W-1:0] row;
        logic [SBS_MA_W-1:0]  col_ma;
    } sbs_cmd_pkt_t;

    typedef struct packed {
        logic                 hit;
        logic [1:0]           ext;
        logic [1:0]           ib;
        logic [SBS_ROW_W-1:0] row;
        logic [SBS_COL_W-1:0] col;
    } sbs_map_t;

    typedef struct packed {
        logic [2:0]                           mode;
        logic [15:0]                          geom;
        logic [31:0]                          ends;
        logic [SBS_PAGES-1:0]                 pt_valid;
        logic [SBS_PAGES-1:0][SBS_ROW_W-1:0]  pt_row;
        logic [31:0]                          rdata;
        sbs_cmd_pkt_t                         cmd;
    } sbs_state_t;

    // column count from the two-bit width code
    function automatic int sbs_cols(input logic [1:0] code);
        unique case (code)
            2'h0: sbs_cols = 8;
            2'h1: sbs_cols = 9;
            2'h2: sbs_cols = 11;
            2'h3: sbs_cols = 10;
        endcase
    endfunction : sbs_cols

endpackage : sbs_pkg

// *** sbs_addr_map.sv ***
`timescale 1ns/1ps
module sbs_addr_map
    import sbs_pkg::*;
(
    input  wire logic [31:0] addr,
    input  wire logic [15:0] geom,
    input  wire logic [31:0] ends,
    output sbs_map_t         map
);

    always_comb begin
        logic [SBS_UNIT_W-1:0] unit;
        logic [SBS_UNIT_W-1:0] lo;
        logic [SBS_UNIT_W-1:0] endv;
        logic [3:0]            nib;
        logic [29:0]           low;
        logic [29:0]           rest;
        logic [29:0]           upper;
        logic [SBS_COL_W-1:0]  mask;
        int                    cols;
        map   = '0;
        lo    = '0;
        endv  = '0;
        nib   = '0;
        cols  = 0;
        mask  = '0;
        low   = '0;
        rest  = '0;
        upper = '0;
        unit  = addr[SBS_UNIT_LSB +: SBS_UNIT_W];
        // lowest enabled bank whose window holds the address wins
        for (int i = 0; i < SBS_EXT_BANKS; i++) begin
            endv = ends[SBS_END_W*i +: SBS_UNIT_W];
            if (ends[SBS_END_W*i + SBS_END_EN_POS]) begin
                if (!map.hit && unit >= lo && unit < endv) begin
                    map.hit = 1'b1;
                    map.ext = i[1:0];
                end
                lo = endv;
            end
        end
        nib  = geom[SBS_NIB_W*map.ext +: SBS_NIB_W];
        cols = sbs_cols(nib[SBS_COL_POS +: 2]);
        // column width only sets the page width, not the bank size
        mask = SBS_COL_W'((1 << cols) - 1);
        low  = addr[31:2];
        map.col = low[SBS_COL_W-1:0] & mask;
        // address bits above the true geometry alias onto the same cells
        rest  = low >> cols;
        map.ib[0]  = rest[0];
        map.row[SBS_ROW_LOW_W-2:0] = rest[SBS_ROW_LOW_W-1:1];
        upper = rest >> SBS_ROW_LOW_W;
        // upper row bits land on address bits 27-25 at maximum geometry
        if (nib[SBS_IB4_POS]) begin
            map.ib[1] = upper[0];
            map.row[SBS_ROW_W-1:SBS_ROW_LOW_W-1] = upper[3:1];
        end else begin
            map.ib[1] = 1'b0;
            map.row[SBS_ROW_W-1:SBS_ROW_LOW_W-1] = upper[2:0];
        end
    end

endmodule : sbs_addr_map

// *** sbs_bank_sizing.sv ***
`timescale 1ns/1ps
module sbs_bank_sizing
    import sbs_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    output logic      [31:0]  reg_rdata,
    input  sbs_req_t          req,
    output logic              req_ready,
    output sbs_cmd_pkt_t      cmd_out
);

    sbs_state_t s_r;
    sbs_state_t s_nxt;
    sbs_map_t   map;
    logic [3:0] pg_idx;
    logic       pg_open;
    logic       pg_same;

    sbs_addr_map sbs_addr_map_inst (
        .addr (req.addr),
        .geom (s_r.geom),
        .ends (s_r.ends),
        .map  (map)
    );

    assign pg_idx    = {map.ext, map.ib};
    assign pg_open   = s_r.pt_valid[pg_idx];
    assign pg_same   = s_r.pt_row[pg_idx] == map.row;
    assign req_ready = ~rst;
    assign reg_rdata = s_r.rdata;
    assign cmd_out   = s_r.cmd;

    always_comb begin
        s_nxt           = s_r;
        s_nxt.cmd       = '0;
        // configuration port, one word per offset
        if (reg_wr) begin
            unique case (reg_addr)
                SBS_OFS_CTRL:
                    s_nxt.mode = reg_wdata[SBS_MODE_POS +: 3];
                SBS_OFS_GEOM: s_nxt.geom = reg_wdata[15:0];
                SBS_OFS_ENDS: s_nxt.ends = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                SBS_OFS_CTRL:  s_nxt.rdata = {29'h0, s_r.mode};
                SBS_OFS_GEOM:  s_nxt.rdata = {16'h0, s_r.geom};
                SBS_OFS_ENDS:  s_nxt.rdata = s_r.ends;
                SBS_OFS_PAGES: s_nxt.rdata = {16'h0, s_r.pt_valid};
                default:       s_nxt.rdata = 32'h00000000;
            endcase
        end
        if (req.valid) begin
            s_nxt.cmd.write = req.write;
            unique case (s_r.mode)
                SBS_MODE_NORMAL: begin
                    if (map.hit) begin
                        s_nxt.cmd.valid  = 1'b1;
                        s_nxt.cmd.cs     = 4'(1 << map.ext);
                        s_nxt.cmd.ib     = map.ib;
                        s_nxt.cmd.row    = map.row;
                        s_nxt.cmd.col_ma = SBS_MA_W'(map.col);
                        // track the open row per internal bank
                        if (pg_open && pg_same) begin
                            s_nxt.cmd.cmd = SBS_CMD_ACC_HIT;
                        end else if (pg_open) begin
                            s_nxt.cmd.cmd = SBS_CMD_ACC_SWAP;
                        end else begin
                            s_nxt.cmd.cmd = SBS_CMD_ACC_OPEN;
                        end
                        s_nxt.pt_valid[pg_idx] = 1'b1;
                        s_nxt.pt_row[pg_idx]   = map.row;
                    end
                end
                SBS_MODE_PRE_ALL: begin
                    s_nxt.cmd.valid = 1'b1;
                    s_nxt.cmd.cmd   = SBS_CMD_PRE_ALL;
                    s_nxt.cmd.cs    = 4'hF;
                    s_nxt.cmd.col_ma[SBS_MA_PRE_POS] = 1'b1;
                    s_nxt.pt_valid  = '0;
                end
                SBS_MODE_LOAD: begin
                    s_nxt.cmd.valid = 1'b1;
                    s_nxt.cmd.cmd   = SBS_CMD_LOAD;
                    s_nxt.cmd.cs    = 4'hF;
                end
                SBS_MODE_REFRESH: begin
                    s_nxt.cmd.valid = 1'b1;
                    s_nxt.cmd.cmd   = SBS_CMD_REFRESH;
                    s_nxt.cmd.cs    = 4'hF;
                end
                default: begin
                    s_nxt.cmd.valid = 1'b1;
                    s_nxt.cmd.cmd   = SBS_CMD_NOP;
                    s_nxt.cmd.cs    = 4'hF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r          <= '0;
            s_r.mode     <= SBS_MODE_RST;
            s_r.geom     <= SBS_GEOM_RST;
            s_r.ends     <= SBS_ENDS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_PRE_ON_MODE: assert property (
        req.valid && s_r.mode == SBS_MODE_PRE_ALL
        |=> cmd_out.valid && cmd_out.cmd == SBS_CMD_PRE_ALL)
        else $error("precharge mode access gave no precharge");

    AST_PRE_NEEDS_CYCLE: assert property (
        cmd_out.valid && cmd_out.cmd == SBS_CMD_PRE_ALL
        |-> $past(req.valid) && $past(s_r.mode) == SBS_MODE_PRE_ALL)
        else $error("precharge issued without an access");

    AST_PT_CLEARED: assert property (
        cmd_out.valid && cmd_out.cmd == SBS_CMD_PRE_ALL
        |-> s_r.pt_valid == '0)
        else $error("page table survived precharge");

    AST_PRE_ALL_BANKS: assert property (
        cmd_out.valid && cmd_out.cmd == SBS_CMD_PRE_ALL
        |-> cmd_out.cs == 4'hF && cmd_out.col_ma[SBS_MA_PRE_POS])
        else $error("precharge not applied to all banks");

    AST_TWO_BANKS: assert property (
        map.hit && !s_r.geom[SBS_NIB_W*map.ext + SBS_IB4_POS]
        |-> map.ib[1] == 1'b0)
        else $error("two bank device used upper bank select");

    AST_END_BOUND: assert property (
        map.hit |-> req.addr[SBS_UNIT_LSB +: SBS_UNIT_W]
            < s_r.ends[SBS_END_W*map.ext +: SBS_UNIT_W])
        else $error("address decoded beyond bank end");

    AST_COL_WIDTH: assert property (
        map.hit |-> (map.col >> sbs_cols(
            s_r.geom[SBS_NIB_W*map.ext +: 2])) == '0)
        else $error("column wider than configured");

    AST_PAGE_TRACK: assert property (
        req.valid && s_r.mode == SBS_MODE_NORMAL && map.hit
        ##1 req.valid && s_r.mode == SBS_MODE_NORMAL && map.hit
            && pg_idx == $past(pg_idx) && map.row == $past(map.row)
        |=> cmd_out.cmd == SBS_CMD_ACC_HIT)
        else $error("repeat of open row not a page hit");

    AST_NO_SPURIOUS_CMD: assert property (
        !req.valid |=> !cmd_out.valid)
        else $error("command issued without an access");

    AST_MISS_DROPPED: assert property (
        req.valid && s_r.mode == SBS_MODE_NORMAL && !map.hit
        |=> !cmd_out.valid)
        else $error("access outside every bank reached the devices");

    AST_ONE_BANK_SELECT: assert property (
        cmd_out.valid && cmd_out.cmd inside {SBS_CMD_ACC_OPEN,
            SBS_CMD_ACC_HIT, SBS_CMD_ACC_SWAP}
        |-> $onehot(cmd_out.cs))
        else $error("normal access selected other than one bank");

    AST_FORCED_ALL_SELECT: assert property (
        req.valid && s_r.mode != SBS_MODE_NORMAL
        |=> cmd_out.valid && cmd_out.cs == 4'hF)
        else $error("forced command not applied to all banks");

    AST_RDATA_HOLDS: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_PAGE_RECORDED: assert property (
        req.valid && s_r.mode == SBS_MODE_NORMAL && map.hit
        |=> s_r.pt_valid[$past(pg_idx)]
            && s_r.pt_row[$past(pg_idx)] == $past(map.row))
        else $error("access did not record its open row");

    CVR_PRE_ALL: cover property (
        cmd_out.valid && cmd_out.cmd == SBS_CMD_PRE_ALL);
    CVR_HIT: cover property (
        cmd_out.valid && cmd_out.cmd == SBS_CMD_ACC_HIT);
    CVR_SWAP: cover property (
        cmd_out.valid && cmd_out.cmd == SBS_CMD_ACC_SWAP);
    CVR_OPEN: cover property (
        cmd_out.valid && cmd_out.cmd == SBS_CMD_ACC_OPEN);

endmodule : sbs_bank_sizing

// *** sbs_sdram_model.sv ***
`timescale 1ns/1ps
module sbs_sdram_model
    import sbs_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire sbs_cmd_pkt_t cmd_in,
    output logic [4:0]        open_cnt,
    output logic              proto_err
);
    logic [15:0]                open_r;
    logic [15:0][SBS_ROW_W-1:0] row_r;
    int                         idx;

    assign open_cnt = 5'($countones(open_r));

    // one page per device bank; a hit on a closed or other row is flagged
    always @(posedge clk_sys) begin
        if (rst) begin
            open_r    <= '0;
            proto_err <= 1'b0;
        end else if (cmd_in.valid) begin
            if (cmd_in.cmd == SBS_CMD_PRE_ALL && cmd_in.col_ma[10]) begin
                open_r <= '0;
            end
            for (int k = 0; k < 4; k++) begin
                idx = k * 4 + int'(cmd_in.ib);
                if (cmd_in.cs[k] && cmd_in.cmd == SBS_CMD_ACC_OPEN) begin
                    if (open_r[idx]) proto_err <= 1'b1;
                    open_r[idx] <= 1'b1;
                    row_r[idx]  <= cmd_in.row;
                end
                if (cmd_in.cs[k] && cmd_in.cmd == SBS_CMD_ACC_HIT) begin
                    if (!open_r[idx] || row_r[idx] != cmd_in.row) begin
                        proto_err <= 1'b1;
                    end
                end
                if (cmd_in.cs[k] && cmd_in.cmd == SBS_CMD_ACC_SWAP) begin
                    if (!open_r[idx] || row_r[idx] == cmd_in.row) begin
                        proto_err <= 1'b1;
                    end
                    row_r[idx] <= cmd_in.row;
                end
            end
        end
    end
endmodule : sbs_sdram_model

// *** sbs_bank_sizing_tb.sv ***
`timescale 1ns/1ps
module sbs_bank_sizing_tb
    import sbs_pkg::*;
;
    logic         clk_sys   = 1'b0;
    logic         rst       = 1'b1;
    logic         reg_wr    = 1'b0;
    logic         reg_rd    = 1'b0;
    logic [7:0]   reg_addr  = 8'h00;
    logic [31:0]  reg_wdata = 32'h0;
    sbs_req_t     req       = '0;
    logic [31:0]  reg_rdata;
    logic         req_ready;
    sbs_cmd_pkt_t cmd_out;
    sbs_cmd_pkt_t seen;
    logic [4:0]   open_cnt;
    logic         proto_err;
    logic [31:0]  rv;
    int           bad_count = 0;
    int           n_tests   = 0;
    int           cyc       = 0;

    always #2 clk_sys = ~clk_sys;

    sbs_bank_sizing sbs_bank_sizing_inst (.clk_sys(clk_sys), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .req(req),
        .req_ready(req_ready), .cmd_out(cmd_out));
    sbs_sdram_model sbs_sdram_model_inst (.clk_sys(clk_sys), .rst(rst),
        .cmd_in(cmd_out), .open_cnt(open_cnt), .proto_err(proto_err));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk32(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk32

    task automatic chk_cmd(input sbs_cmd_t e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value cmd expected %h seen %h", e, g);
        end
    endtask : chk_cmd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk32("reg", e, reg_rdata);
    endtask : rdr

    task automatic acc(input logic [31:0] a, input logic v,
                       input sbs_cmd_t c, input logic [3:0] cs);
        @(posedge clk_sys);
        req <= '{valid: 1'b1, write: a[9], addr: a};
        @(posedge clk_sys);
        req.valid <= 1'b0;
        #1 seen = cmd_out;
        chk32("valid", {31'h0, v}, {31'h0, seen.valid});
        if (v) begin
            chk32("write", {31'h0, a[9]}, {31'h0, seen.write});
            chk_cmd(c, seen.cmd);
            chk32("cs", {28'h0, cs}, {28'h0, seen.cs});
        end
    endtask : acc

    task automatic acc_pair(input logic [31:0] a, input sbs_cmd_t c);
        @(posedge clk_sys);
        req <= '{valid: 1'b1, write: 1'b0, addr: a};
        @(posedge clk_sys);
        #1 chk_cmd(c, cmd_out.cmd);
        @(posedge clk_sys);
        req.valid <= 1'b0;
        #1 chk_cmd(SBS_CMD_ACC_HIT, cmd_out.cmd);
    endtask : acc_pair

    task automatic pre_all;
        wr(SBS_OFS_CTRL, {29'h0, SBS_MODE_PRE_ALL});
        repeat (2) @(posedge clk_sys);
        #1 chk32("idle", 32'h0, {31'h0, cmd_out.valid});
        acc(32'h0, 1'b1, SBS_CMD_PRE_ALL, 4'hF);
        chk32("ma10", 32'h1, {31'h0, seen.col_ma[10]});
        wr(SBS_OFS_CTRL, {29'h0, SBS_MODE_NORMAL});
    endtask : pre_all

    task automatic t_reset;
        logic [7:0] ofs[5] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
        foreach (ofs[i]) rdr(ofs[i], 32'h0);
        chk32("ready", 32'h1, {31'h0, req_ready});
        acc(32'h0, 1'b0, SBS_CMD_NOP, 4'h0);
    endtask : t_reset

    task automatic t_modes;
        logic [2:0] m[3] = '{SBS_MODE_NOP, SBS_MODE_LOAD, SBS_MODE_REFRESH};
        sbs_cmd_t   c[3] = '{SBS_CMD_NOP, SBS_CMD_LOAD, SBS_CMD_REFRESH};
        for (int i = 0; i < 3; i++) begin
            wr(SBS_OFS_CTRL, {29'h0, m[i]});
            acc(32'h0E000000, 1'b1, c[i], 4'hF);
        end
        pre_all();
    endtask : t_modes

    task automatic t_max_cfg;
        wr(SBS_OFS_GEOM, 32'h0000A000);
        wr(SBS_OFS_ENDS, 32'hFF000000);
        rdr(SBS_OFS_GEOM, 32'h0000A000);
        rdr(SBS_OFS_ENDS, 32'hFF000000);
        acc(32'h0E001E00, 1'b1, SBS_CMD_ACC_OPEN, 4'h8);
        chk32("row", 32'h1C00, {19'h0, seen.row});
        chk32("col", 32'h00000780, {19'h0, seen.col_ma});
        acc(32'h0E000E00, 1'b1, SBS_CMD_ACC_HIT, 4'h8);
        acc(32'h0E000600, 1'b1, SBS_CMD_ACC_HIT, 4'h8);
        acc(32'h0E000200, 1'b1, SBS_CMD_ACC_HIT, 4'h8);
        acc(32'h0E001E00, 1'b1, SBS_CMD_ACC_HIT, 4'h8);
        acc(32'h0F000000, 1'b1, SBS_CMD_ACC_OPEN, 4'h8);
        chk32("ib", 32'h2, {30'h0, seen.ib});
        acc(32'h07000000, 1'b1, SBS_CMD_ACC_SWAP, 4'h8);
        acc(32'h03000000, 1'b1, SBS_CMD_ACC_SWAP, 4'h8);
        acc(32'h01000000, 1'b1, SBS_CMD_ACC_SWAP, 4'h8);
        acc(32'h00000000, 1'b1, SBS_CMD_ACC_SWAP, 4'h8);
        acc(32'h03000000, 1'b1, SBS_CMD_ACC_SWAP, 4'h8);
        rdr(SBS_OFS_PAGES, 32'h00005000);
        wr(SBS_OFS_PAGES, 32'h0000FFFF);
        rdr(SBS_OFS_PAGES, 32'h00005000);
        chk32("open", 32'h2, {27'h0, open_cnt});
        pre_all();
        rdr(SBS_OFS_PAGES, 32'h0);
        chk32("open", 32'h0, {27'h0, open_cnt});
    endtask : t_max_cfg

    task automatic t_two_bank;
        wr(SBS_OFS_GEOM, 32'h00002000);
        acc(32'h0F000000, 1'b1, SBS_CMD_ACC_OPEN, 4'h8);
        chk32("ib", 32'h0, {30'h0, seen.ib});
        acc_pair(32'h01000000, SBS_CMD_ACC_SWAP);
        pre_all();
    endtask : t_two_bank

    task automatic t_end;
        wr(SBS_OFS_GEOM, 32'h0000000A);
        wr(SBS_OFS_ENDS, 32'h00000081);
        acc(32'h003FFFFC, 1'b1, SBS_CMD_ACC_OPEN, 4'h1);
        acc(32'h00400000, 1'b0, SBS_CMD_NOP, 4'h0);
        chk32("proto", 32'h0, {31'h0, proto_err});
    endtask : t_end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (7) @(posedge clk_sys);
        #1 chk32("ready", 32'h0, {31'h0, req_ready});
        @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_max_cfg();
        t_two_bank();
        t_end();
        wrap_up();
    end
endmodule : sbs_bank_sizing_tb
